// file: rtl/esd_top.sv
/*
 emitter safety sequencing and per-slot photodiode routing.
 assumes a byte register port from the host bridge and a sequencer that
 requests measurements and names the active sequence and subsample.
*/
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - monitoring starts a programmed count of microseconds after emitter on
// - short to ground test runs before every measurement
// - a detected short suppresses the following measurement
// - emitter forced off after about 3 ms on, unless bit 7 set
// - bit 6 makes safety evaluation ignore both short detectors
// - bits 5:4 select comparator threshold 50 to 200 mV
// - bits 3:2 set supply short settling 2, 4, 8, 12 us
// - bits 1:0 set ground short settling 2, 4, 8, 12 us
// - a separate routing word applies in every subsample slot
// - bits 6:4 route diodes to modulator a, 2:0 to b, bit 7 zero
// - one diode on one modulator at a time, shared ones serialised
// - distinct diodes on different modulators convert together
// - modulator a takes diodes only; bit 3 gives b test voltages
// - with bit 3 set, bits 2:0 pick b's test voltage
// - result is a 20-bit signed fraction of full scale
// - slot one of sequence one resets to no diode connected
// - test codes: emitters, supply, anode, ground, vdd, temperature
module esd_top #(
   parameter int SLOTS = 16,
   parameter int ONTIME_CYC = esd_pkg::ONTIME_MAX_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic meas_req,
   input wire logic [$clog2(SLOTS)-1:0] slot_idx,
   input wire logic short_gnd_det,
   input wire logic short_vdd_det,
   input wire logic [19:0] adc_raw,
   input wire logic adc_valid,
   output logic emitter_on,
   output logic short_gnd_en,
   output logic short_vdd_en,
   output logic [8:0] vref_mv,
   output logic monitor_active,
   output logic meas_start,
   output logic meas_blocked,
   output logic ontime_trip,
   output esd_pkg::esd_mux_t mux_sel,
   output logic [2:0] interleave_slot,
   output logic signed [19:0] result,
   output logic result_valid
);
   localparam int SW = $clog2(SLOTS);
   esd_pkg::esd_cfg_t cfg;
   logic [7:0] mon_delay;
   esd_pkg::esd_route_t route [SLOTS];
   esd_pkg::esd_state_t state;
   logic [15:0] tcnt;
   logic [$clog2(ONTIME_CYC+1)-1:0] on_cnt;
   logic [2:0] sg_s, sv_s;
   logic [15:0] settle_vss, settle_vdd, mon_cyc;
   logic sg_ok, sv_ok, trip_now;
   logic [1:0] il_ptr;
   logic sg_f, sv_f;
   logic [2:0] a_sel, b_sel, a_now, b_now;

   function automatic logic [15:0] settle(input logic [1:0] c);
      case (c)
         2'd0: settle = 16'(esd_pkg::SETTLE_US_0 * esd_pkg::CYC_PER_US);
         2'd1: settle = 16'(esd_pkg::SETTLE_US_1 * esd_pkg::CYC_PER_US);
         2'd2: settle = 16'(esd_pkg::SETTLE_US_2 * esd_pkg::CYC_PER_US);
         default: settle = 16'(esd_pkg::SETTLE_US_3 * esd_pkg::CYC_PER_US);
      endcase
   endfunction

   assign settle_vdd = settle(cfg.vdd_wait);
   assign settle_vss = settle(cfg.vss_wait);
   assign mon_cyc = 16'(mon_delay) * 16'(esd_pkg::CYC_PER_US);
   assign sg_ok = cfg.safety_eval_off | ~sg_f;
   assign sv_ok = cfg.safety_eval_off | ~sv_f;

   // detector inputs come from analog, three-stage synchronisers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sg_s <= 3'h0;
         sv_s <= 3'h0;
         sg_f <= 1'b0;
         sv_f <= 1'b0;
      end else begin
         sg_s <= {sg_s[1:0], short_gnd_det};
         sv_s <= {sv_s[1:0], short_vdd_det};
         // level taken once second and third stage agree
         if (sg_s[2] == sg_s[1]) begin
            sg_f <= sg_s[2];
         end
         if (sv_s[2] == sv_s[1]) begin
            sv_f <= sv_s[2];
         end
      end
   end

   // register writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= esd_pkg::CFG_RESET;
         mon_delay <= esd_pkg::DELAY_RESET;
      end else if (reg_wr) begin
         if (reg_addr == esd_pkg::ADDR_SAFETY_CFG) begin
            cfg <= reg_wdata;
         end else if (reg_addr == esd_pkg::ADDR_MON_DELAY) begin
            mon_delay <= reg_wdata;
         end
      end
   end

   for (genvar g = 0; g < SLOTS; g++) begin : g_route
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            route[g] <= esd_pkg::ROUTE_RESET[6:0];
         end else if (reg_wr &&
                      reg_addr == esd_pkg::ADDR_ROUTE_BASE + 8'(g)) begin
            route[g] <= reg_wdata[6:0];
         end
      end
   end

   // readback; unused bits zero
   always_comb begin
      reg_rdata = 8'h00;
      if (reg_addr == esd_pkg::ADDR_SAFETY_CFG) begin
         reg_rdata = cfg;
      end else if (reg_addr == esd_pkg::ADDR_MON_DELAY) begin
         reg_rdata = mon_delay;
      end else if (reg_addr >= esd_pkg::ADDR_ROUTE_BASE &&
                   reg_addr < esd_pkg::ADDR_ROUTE_BASE + 8'(SLOTS)) begin
         reg_rdata = {1'b0,
                      route[SW'(reg_addr - esd_pkg::ADDR_ROUTE_BASE)]};
      end
   end

   always_comb begin
      case (cfg.vref_sel)
         2'd0: vref_mv = esd_pkg::VREF_MV_0;
         2'd1: vref_mv = esd_pkg::VREF_MV_1;
         2'd2: vref_mv = esd_pkg::VREF_MV_2;
         default: vref_mv = esd_pkg::VREF_MV_3;
      endcase
   end

   assign trip_now = !cfg.ontime_guard_off && emitter_on &&
                     on_cnt >= ($bits(on_cnt))'(ONTIME_CYC);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         on_cnt <= '0;
         ontime_trip <= 1'b0;
      end else begin
         on_cnt <= emitter_on ? on_cnt + 1'b1 : '0;
         ontime_trip <= trip_now;
      end
   end

   // safety sequence
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= esd_pkg::ST_IDLE;
         tcnt <= 16'h0000;
         meas_start <= 1'b0;
         meas_blocked <= 1'b0;
      end else begin
         meas_start <= 1'b0;
         meas_blocked <= 1'b0;
         tcnt <= tcnt + 16'h0001;
         case (state)
            esd_pkg::ST_IDLE: begin
               tcnt <= 16'h0000;
               if (meas_req) begin
                  state <= esd_pkg::ST_VSS_TEST;
               end
            end
            esd_pkg::ST_VSS_TEST: begin
               if (tcnt + 16'h0001 >= settle_vss) begin
                  tcnt <= 16'h0000;
                  if (!sg_ok) begin
                     state <= esd_pkg::ST_FAULT;
                  end else begin
                     state <= esd_pkg::ST_VDD_TEST;
                  end
               end
            end
            esd_pkg::ST_VDD_TEST: begin
               if (tcnt + 16'h0001 >= settle_vdd) begin
                  tcnt <= 16'h0000;
                  if (!sv_ok) begin
                     state <= esd_pkg::ST_FAULT;
                  end else begin
                     state <= esd_pkg::ST_WAIT_MON;
                     meas_start <= 1'b1;
                  end
               end
            end
            esd_pkg::ST_WAIT_MON: begin
               if (trip_now) begin
                  state <= esd_pkg::ST_IDLE;
               end else if (tcnt >= mon_cyc) begin
                  state <= esd_pkg::ST_MEASURE;
               end
            end
            esd_pkg::ST_MEASURE: begin
               if (!meas_req || trip_now) begin
                  state <= esd_pkg::ST_IDLE;
               end
            end
            default: begin
               meas_blocked <= 1'b1;
               state <= esd_pkg::ST_IDLE;
            end
         endcase
      end
   end

   assign emitter_on = (state == esd_pkg::ST_WAIT_MON ||
                        state == esd_pkg::ST_MEASURE) && !ontime_trip;
   assign monitor_active = state == esd_pkg::ST_MEASURE;
   assign short_gnd_en = state == esd_pkg::ST_VSS_TEST;
   assign short_vdd_en = state == esd_pkg::ST_VDD_TEST;

   // serialise shared diodes, one per measure cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         il_ptr <= 2'd0;
      end else if (state != esd_pkg::ST_MEASURE) begin
         il_ptr <= 2'd0;
      end else begin
         il_ptr <= (il_ptr == 2'd2) ? 2'd0 : il_ptr + 2'd1;
      end
   end
   assign interleave_slot = 3'b001 << il_ptr;

   always_comb begin
      a_sel = route[slot_idx].diodes_a;
      b_sel = route[slot_idx].test_sel ? 3'h0 : route[slot_idx].sel_b;
      a_now = |(a_sel & (a_sel - 3'h1)) ? a_sel & interleave_slot : a_sel;
      b_now = |(b_sel & (b_sel - 3'h1)) ? b_sel & interleave_slot : b_sel;
      b_now = b_now & ~a_now;
   end

   // routing to modulators
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mux_sel <= '0;
      end else if (state != esd_pkg::ST_MEASURE) begin
         mux_sel <= '0;
      end else begin
         mux_sel.diode_a <= a_now;
         mux_sel.test_en <= route[slot_idx].test_sel;
         mux_sel.test_code <= route[slot_idx].test_sel ?
                              route[slot_idx].sel_b : 3'h0;
         mux_sel.diode_b <= b_now;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result <= 20'h00000;
         result_valid <= 1'b0;
      end else begin
         result_valid <= adc_valid && monitor_active;
         if (adc_valid && monitor_active) begin
            result <= adc_raw;
         end
      end
   end

   AST_NO_START_ON_FAULT: assert property (@(posedge clk) disable iff (!rst_n)
      (state == esd_pkg::ST_FAULT) |=> !meas_start && meas_blocked)
      else $error("measurement started after short");
   AST_TEST_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(meas_start) |-> $past(state) == esd_pkg::ST_VDD_TEST)
      else $error("measurement without short test");
   AST_TRIP_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      trip_now |=> !emitter_on)
      else $error("emitter stayed on past limit");
   AST_GUARD_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      cfg.ontime_guard_off && state == esd_pkg::ST_MEASURE && meas_req
      |=> emitter_on)
      else $error("watchdog tripped while disabled");
   AST_MASK: assert property (@(posedge clk) disable iff (!rst_n)
      cfg.safety_eval_off && state == esd_pkg::ST_VSS_TEST
      |=> state != esd_pkg::ST_FAULT)
      else $error("fault raised while evaluation off");
   AST_A_DIODES: assert property (@(posedge clk) disable iff (!rst_n)
      $countones(mux_sel.diode_a) <= 1 &&
      $countones(mux_sel.diode_b) <= 1 &&
      (mux_sel.diode_a & mux_sel.diode_b) == 3'h0)
      else $error("diode shared");
   AST_B_TEST: assert property (@(posedge clk) disable iff (!rst_n)
      mux_sel.test_en |-> mux_sel.diode_b == 3'h0)
      else $error("modulator b mixes test and diode");
   AST_MON_DELAY: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(monitor_active) |-> $past(tcnt) >= $past(mon_cyc))
      else $error("monitoring before delay");
endmodule
`default_nettype wire

// file: rtl/esd_pkg.sv
/*
 emitter safety and diode routing: constants, field layouts, carriers.
 assumes a 20 MHz sequencer clock and byte-wide register access.
*/
package esd_pkg;
   // register map
   localparam logic [7:0] ADDR_SAFETY_CFG = 8'h28;
   localparam logic [7:0] ADDR_MON_DELAY = 8'h35;
   localparam logic [7:0] ADDR_ROUTE_BASE = 8'h53;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] DELAY_RESET = 8'h00;
   localparam logic [7:0] ROUTE_RESET = 8'h00;
   localparam logic [7:0] ROUTE_MASK = 8'h7F;
   // safety config fields
   localparam int CFG_GUARD_OFF_BIT = 7;
   localparam int CFG_SAFETY_OFF_BIT = 6;
   localparam int CFG_VREF_LSB = 4;
   localparam int CFG_VDD_WAIT_LSB = 2;
   localparam int CFG_VSS_WAIT_LSB = 0;
   // routing word fields
   localparam int ROUTE_A_LSB = 4;
   localparam int ROUTE_B_LSB = 0;
   localparam int ROUTE_TEST_BIT = 3;
   // timing
   localparam int CLK_MHZ = 20;
   localparam int CYC_PER_US = CLK_MHZ;
   localparam int ONTIME_MAX_US = 3000;
   localparam int ONTIME_MAX_CYC = ONTIME_MAX_US * CLK_MHZ;
   localparam int SETTLE_US_0 = 2;
   localparam int SETTLE_US_1 = 4;
   localparam int SETTLE_US_2 = 8;
   localparam int SETTLE_US_3 = 12;
   localparam logic [8:0] VREF_MV_0 = 9'h032;
   localparam logic [8:0] VREF_MV_1 = 9'h064;
   localparam logic [8:0] VREF_MV_2 = 9'h096;
   localparam logic [8:0] VREF_MV_3 = 9'h0C8;
   // test voltage select codes on modulator_b
   localparam logic [2:0] TV_GROUND_REF = 3'h4;

   typedef struct packed {
      logic ontime_guard_off;
      logic safety_eval_off;
      logic [1:0] vref_sel;
      logic [1:0] vdd_wait;
      logic [1:0] vss_wait;
   } esd_cfg_t;

   typedef struct packed {
      logic [2:0] diodes_a;
      logic test_sel;
      logic [2:0] sel_b;
   } esd_route_t;

   typedef struct packed {
      logic [2:0] diode_a;
      logic [2:0] diode_b;
      logic test_en;
      logic [2:0] test_code;
   } esd_mux_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_VSS_TEST = 3'b001,
      ST_VDD_TEST = 3'b011,
      ST_WAIT_MON = 3'b010,
      ST_MEASURE = 3'b110,
      ST_FAULT = 3'b111
   } esd_state_t;
endpackage

// file: verification/esd_far_model.sv
/*
 far-side model: the emitter short detectors seen by the safety logic.
 assumes detector enables come straight from the block under test.
*/
`timescale 1ns/1ns
`default_nettype none
module esd_far_model (
   input wire logic short_gnd_en,
   input wire logic short_vdd_en,
   input wire logic gnd_fault,
   input wire logic vdd_fault,
   output logic short_gnd_det,
   output logic short_vdd_det
);
   // detector reports only while its test runs
   assign short_gnd_det = short_gnd_en & gnd_fault;
   assign short_vdd_det = short_vdd_en & vdd_fault;
endmodule
`default_nettype wire

// file: verification/emitter_safety_and_diode_routing_bench.sv
/*
 bench: registers, safety sequencing, watchdog and per-slot routing.
 assumes esd_top with a short on-time limit and the far-side model.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
   $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module emitter_safety_and_diode_routing_bench;
   logic clk, rst_n, reg_wr, meas_req, adc_valid, gf, vf;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [3:0] slot_idx;
   logic [19:0] adc_raw;
   wire logic gnd_det;
   wire logic vdd_det;
   logic emitter_on, gnd_en, vdd_en, mon, m_start, m_blk, trip, res_v;
   logic [8:0] vref_mv;
   esd_pkg::esd_mux_t mux_sel;
   logic [2:0] ilv;
   logic signed [19:0] result;
   int fails = 0, n_compared = 0, cyc = 0, ng, nv, n, k, orv;
   int st[4] = '{2, 4, 8, 12};

   esd_top #(.SLOTS(16), .ONTIME_CYC(200)) DUT (.clk(clk), .rst_n(rst_n),
      .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .meas_req(meas_req), .slot_idx(slot_idx),
      .short_gnd_det(gnd_det), .short_vdd_det(vdd_det), .adc_raw(adc_raw),
      .adc_valid(adc_valid), .emitter_on(emitter_on), .short_gnd_en(gnd_en),
      .short_vdd_en(vdd_en), .vref_mv(vref_mv), .monitor_active(mon),
      .meas_start(m_start), .meas_blocked(m_blk), .ontime_trip(trip),
      .mux_sel(mux_sel), .interleave_slot(ilv), .result(result),
      .result_valid(res_v));
   esd_far_model far (.short_gnd_en(gnd_en), .short_vdd_en(vdd_en),
      .gnd_fault(gf), .vdd_fault(vf), .short_gnd_det(gnd_det),
      .short_vdd_det(vdd_det));

   task complete_run;
      if (fails == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rc(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      @(negedge clk);
      `CHK(reg_rdata, e)
   endtask
   task go(input logic blk);
      ng = 0;
      nv = 0;
      @(posedge clk);
      meas_req <= 1'b1;
      for (n = 0; n < 700 && !(m_start || m_blk); n++) @(negedge clk);
      `CHK(m_blk, blk)
      `CHK(m_start, !blk)
   endtask
   task stop;
      @(posedge clk);
      meas_req <= 1'b0;
      repeat (300) @(posedge clk);
   endtask
   task sel(input logic [3:0] s);
      @(posedge clk);
      slot_idx <= s;
      repeat (3) @(negedge clk);
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(negedge clk) begin
      if (gnd_en)
         ng++;
      if (vdd_en)
         nv++;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         complete_run;
      end
   end

   initial begin
      rst_n = 1'b0;
      {reg_wr, meas_req, adc_valid, gf, vf} = 5'h00;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      slot_idx = 4'h0;
      adc_raw = 20'h00000;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rc(esd_pkg::ADDR_SAFETY_CFG, 8'h00);
      rc(esd_pkg::ADDR_MON_DELAY, 8'h00);
      rc(8'h53, 8'h00); // slot one reset
      wr(8'h53, 8'hFF);
      rc(8'h53, 8'h7F); // top bit dropped
      wr(8'h20, 8'h5A);
      rc(8'h20, 8'h00); // unmapped reads zero
      wr(8'h28, 8'hFF);
      rc(8'h28, 8'hFF);
      for (k = 0; k < 4; k++) begin
         wr(8'h28, 8'(8'h80 | k * 16 | k * 4 | (3 - k)));
         wr(8'h35, 8'(k));
         `CHK(vref_mv, 9'(50 * (k + 1))) // threshold
         go(1'b0);
         `CHK(ng, st[3 - k] * 20) // ground test
         `CHK(nv, st[k] * 20) // supply test
         for (n = 0; n < 100 && !mon; n++) @(negedge clk);
         `CHK(n >= k * 20 && n <= k * 20 + 2, 1'b1) // delay
         stop;
      end
      wr(8'h28, 8'h00);
      gf <= 1'b1;
      go(1'b1); // ground short blocks
      stop;
      gf <= 1'b0;
      vf <= 1'b1;
      go(1'b1); // supply short blocks
      stop;
      gf <= 1'b1;
      wr(8'h28, 8'h40);
      go(1'b0); // detectors ignored
      stop;
      {gf, vf} <= 2'b00;
      wr(8'h28, 8'h00);
      go(1'b0);
      for (n = 0; n < 400 && !trip; n++) @(negedge clk);
      `CHK(n >= 198 && n <= 202, 1'b1) // trip time
      `CHK(emitter_on, 1'b0) // forced off
      stop;
      wr(8'h28, 8'h80);
      go(1'b0);
      repeat (400) @(negedge clk);
      `CHK(trip, 1'b0) // guard disabled
      `CHK(emitter_on, 1'b1) // emitter kept on
      wr(8'h53, 8'h21);
      wr(8'h54, 8'h1C);
      sel(4'h0);
      `CHK(mux_sel.diode_a, 3'h2) // second diode on a
      `CHK(mux_sel.diode_b, 3'h1) // first on b
      `CHK(mux_sel.test_en, 1'b0) // diodes on b
      sel(4'h1);
      `CHK(mux_sel.diode_a, 3'h1) // a keeps diode
      `CHK(mux_sel.test_en, 1'b1) // test voltage on b
      `CHK(mux_sel.test_code, esd_pkg::TV_GROUND_REF) // ground ref
      for (k = 0; k < 8; k++) begin
         wr(8'h54, 8'(8'h18 | k));
         repeat (3) @(negedge clk);
         `CHK(mux_sel.test_code, 3'(k)) // every code
      end
      wr(8'h62, 8'h70);
      sel(4'hF);
      orv = 0;
      for (k = 0; k < 3; k++) begin
         @(negedge clk);
         `CHK($countones(ilv), 1) // one slot a time
         `CHK($countones(mux_sel.diode_a), 1) // one diode a time
         orv = orv | mux_sel.diode_a;
      end
      `CHK(orv, 7) // all three served
      @(posedge clk);
      adc_raw <= 20'h80001;
      adc_valid <= 1'b1;
      @(posedge clk);
      adc_valid <= 1'b0;
      for (n = 0; n < 10 && !res_v; n++) @(negedge clk);
      `CHK(res_v, 1'b1) // result strobe
      `CHK(result, 20'sh80001) // signed word
      stop;
      complete_run;
   end
endmodule
`default_nettype wire
